// ==== rtl/gsi_defs.svh ====
// constants of the group shutdown interlock
`ifndef GSI_DEFS_SVH
`define GSI_DEFS_SVH
// ****************************************
// clock and timing
// ****************************************
`define GSI_CLK_HZ 20000000
`define GSI_FDBK_TIME_US 10000
`define GSI_FDBK_CYC ((`GSI_FDBK_TIME_US * (`GSI_CLK_HZ / 1000000)))
// ****************************************
// register offsets
// ****************************************
`define GSI_OFS_FDBK 8'h00
`define GSI_OFS_STATUS 8'h04
`define GSI_OFS_IRQ_STAT 8'h08
`define GSI_OFS_IRQ_MASK 8'h0C
// ****************************************
// fields and reset values
// ****************************************
`define GSI_FDBK_W 24
`define GSI_IRQ_W 6
`define GSI_IRQ_G1_FAULT 0
`define GSI_IRQ_G2_FAULT 1
`define GSI_IRQ_G1_STOP 2
`define GSI_IRQ_G2_STOP 3
`define GSI_IRQ_ALL_STOP 4
`define GSI_IRQ_PASS_RET 5
`define GSI_IRQ_MASK_RST 6'h00
`define GSI_PIN_W 11
`define GSI_PIN_RST 11'h300
`endif

// ==== rtl/gsi_pkg.sv ====
// types of the group shutdown interlock
package gsi_pkg;
  typedef enum logic [1:0] {
    GSI_LOCKED = 2'b00,
    GSI_READY = 2'b01,
    GSI_RUN = 2'b10,
    GSI_FAULT = 2'b11
  } gsi_state_e;
endpackage

// ==== rtl/gsi_group.sv ====
// one actuator group: state machine and readback monitor
`timescale 1ns/1ps
`include "gsi_defs.svh"
module gsi_group (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // filtered field events and levels, and the feedback limit
  input wire logic startPulse,
  input wire logic ackPulse,
  input wire logic stopActive,
  input wire logic passReturn,
  input wire logic readback,
  input wire logic [`GSI_FDBK_W-1:0] fdbkLimit,
  // results
  output logic energise,
  output gsi_pkg::gsi_state_e state,
  output logic faultPulse
);
  gsi_pkg::gsi_state_e stateQ, stateD;
  logic [`GSI_FDBK_W-1:0] mismatchQ;
  logic energiseQ;
  logic cmdOn, mismatch, errNow;

  assign cmdOn = (stateQ == gsi_pkg::GSI_RUN);
  // nc aux contact reads high when dropped out, so it must be the inverse of the command [RULE16]
  assign mismatch = (readback == cmdOn);
  assign errNow = mismatch && (mismatchQ >= fdbkLimit); // [RULE14]

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mismatchQ <= '0;
    end else if (!mismatch || stateQ == gsi_pkg::GSI_FAULT) begin
      mismatchQ <= '0;
    end else if (!errNow) begin
      mismatchQ <= mismatchQ + `GSI_FDBK_W'(1);
    end
  end

  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      gsi_pkg::GSI_LOCKED: begin
        if (ackPulse && readback) begin
          stateD = gsi_pkg::GSI_READY; // [RULE8] [RULE10] [RULE11]
        end
      end
      gsi_pkg::GSI_READY: begin
        if (startPulse && readback) begin
          stateD = gsi_pkg::GSI_RUN; // [RULE3] [RULE15]
        end
      end
      gsi_pkg::GSI_RUN: begin
        stateD = gsi_pkg::GSI_RUN;
      end
      gsi_pkg::GSI_FAULT: begin
        // only once the contact reads dropped out again [RULE12]
        if (ackPulse && !mismatch) begin
          stateD = gsi_pkg::GSI_READY; // [RULE9]
        end
      end
    endcase
    if (errNow) begin
      stateD = gsi_pkg::GSI_FAULT; // [RULE6]
    end else if ((stopActive || passReturn) && stateQ != gsi_pkg::GSI_FAULT) begin
      stateD = gsi_pkg::GSI_LOCKED; // [RULE1] [RULE10] [RULE11]
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= gsi_pkg::GSI_LOCKED; // [RULE8]
    end else begin
      stateQ <= stateD;
    end
  end

  // both contactors of the group hang on this one flop [RULE4] [RULE5] [RULE17]
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      energiseQ <= 1'b0;
    end else begin
      energiseQ <= (stateD == gsi_pkg::GSI_RUN); // [RULE15]
    end
  end

  assign energise = energiseQ;
  assign state = stateQ;
  assign faultPulse = errNow && stateQ != gsi_pkg::GSI_FAULT;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  AST_FAULT_HOLD: assert property ((stateQ == gsi_pkg::GSI_FAULT && !(ackPulse && !mismatch)) |=> // [RULE9]
    stateQ == gsi_pkg::GSI_FAULT) else $error("fault left without acknowledge");
  AST_FAULT_GONE: assert property ((stateQ == gsi_pkg::GSI_FAULT && mismatch) |=> // [RULE12]
    stateQ == gsi_pkg::GSI_FAULT) else $error("fault cleared while readback still wrong");
  AST_LOCK_NO_RUN: assert property ((stateQ == gsi_pkg::GSI_LOCKED) |=> // [RULE10]
    stateQ != gsi_pkg::GSI_RUN) else $error("locked group started without acknowledge");
  AST_FDBK_ERR: assert property (errNow |=> (stateQ == gsi_pkg::GSI_FAULT && !energiseQ)) // [RULE14]
    else $error("feedback timeout not taken as fault");
  AST_PASS_LOCK: assert property ((passReturn && stateQ != gsi_pkg::GSI_FAULT && !errNow) |=> // [RULE11]
    stateQ == gsi_pkg::GSI_LOCKED) else $error("passivation return did not lock group");
endmodule // gsi_group

// ==== rtl/gsi_top.sv ====
// group shutdown interlock: pin filters, two groups, ahb-lite registers
// Summary of operation
// [RULE1] group stop drops only its group
// [RULE2] shared stop drops both groups
// [RULE3] each group starts on its own request
// [RULE4] group one drives two contactors together
// [RULE5] group two drives two contactors together
// [RULE6] readback error drops and holds group
// [RULE7] other group keeps running through error
// [RULE8] first start after reset needs acknowledge
// [RULE9] own or shared acknowledge clears error
// [RULE10] released stop needs acknowledge before restart
// [RULE11] passivation return needs fresh acknowledge
// [RULE12] restart only after fault gone, then acknowledge
// [RULE13] sample start, acknowledge, readback, shared acknowledge
// [RULE14] readback not following command in time: error
// [RULE15] energise only commanded, readback high, no error
// [RULE16] aux contact closed, high when dropped out
// [RULE17] stops active low; contactors off in reset
// [RULE18] acknowledge on release, start on rise
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "gsi_defs.svh"
module gsi_top #(
  parameter logic [`GSI_FDBK_W-1:0] FDBK_DEFAULT = `GSI_FDBK_W'(`GSI_FDBK_CYC)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // field inputs
  input wire logic groupOneEmergencyStopN,
  input wire logic groupTwoEmergencyStopN,
  input wire logic sharedEmergencyStopN,
  input wire logic groupOneStartRequest,
  input wire logic groupTwoStartRequest,
  input wire logic groupOneAcknowledge,
  input wire logic groupTwoAcknowledge,
  input wire logic sharedAcknowledge,
  input wire logic groupOneReadback,
  input wire logic groupTwoReadback,
  input wire logic failsafeInputModulePassive,
  // contactor coils
  output logic groupOneContactorA,
  output logic groupOneContactorB,
  output logic groupTwoContactorA,
  output logic groupTwoContactorB,
  // interrupt
  output logic irq
);
  // ****************************************
  // pin filters
  // ****************************************
  logic [`GSI_PIN_W-1:0] pinRaw, sync1Q, sync2Q, sync3Q, filtQ, prevQ;

  // all field pins pass three flops [RULE13]
  assign pinRaw = {failsafeInputModulePassive, groupTwoReadback, groupOneReadback,
    sharedAcknowledge, groupTwoAcknowledge, groupOneAcknowledge,
    groupTwoStartRequest, groupOneStartRequest,
    sharedEmergencyStopN, groupTwoEmergencyStopN, groupOneEmergencyStopN};

  // reset state reads as stops pressed, so nothing can run before the pins settle
  localparam logic [`GSI_PIN_W-1:0] PIN_RST = `GSI_PIN_RST;
  genvar gi;
  generate
    for (gi = 0; gi < `GSI_PIN_W; gi++) begin : gPin
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          sync1Q[gi] <= PIN_RST[gi];
          sync2Q[gi] <= PIN_RST[gi];
          sync3Q[gi] <= PIN_RST[gi];
          filtQ[gi] <= PIN_RST[gi];
          prevQ[gi] <= PIN_RST[gi];
        end else begin
          sync1Q[gi] <= pinRaw[gi];
          sync2Q[gi] <= sync1Q[gi];
          sync3Q[gi] <= sync2Q[gi];
          // a change counts once two stages agree
          if (sync2Q[gi] == sync3Q[gi]) begin
            filtQ[gi] <= sync3Q[gi];
          end
          prevQ[gi] <= filtQ[gi];
        end
      end
    end
  endgenerate

  logic [`GSI_PIN_W-1:0] riseP, fallP;
  logic stop1, stop2, stopAll, start1P, start2P, ack1P, ack2P, ackAllP;
  logic rdbk1, rdbk2, passReturn;
  assign riseP = filtQ & ~prevQ;
  assign fallP = ~filtQ & prevQ;
  // stops are active low, so a broken wire stops too [RULE17]
  assign stop1 = !filtQ[0];
  assign stop2 = !filtQ[1];
  assign stopAll = !filtQ[2];
  assign start1P = riseP[3]; // [RULE18]
  assign start2P = riseP[4]; // [RULE18]
  assign ack1P = fallP[5]; // [RULE18]
  assign ack2P = fallP[6]; // [RULE18]
  assign ackAllP = fallP[7]; // [RULE18]
  assign rdbk1 = filtQ[8];
  assign rdbk2 = filtQ[9];
  assign passReturn = fallP[10];

  // ****************************************
  // register state
  // ****************************************
  logic [`GSI_FDBK_W-1:0] fdbkQ;
  logic [`GSI_IRQ_W-1:0] irqStatQ, irqStatD, irqMaskQ, irqEvt, irqClr;
  logic irqQ;
  logic wrActQ;
  logic [7:0] wrAddrQ;
  logic [31:0] hrdataQ;
  logic addrPhase;

  // ****************************************
  // groups
  // ****************************************
  logic g1On, g2On, g1Fault, g2Fault;
  gsi_pkg::gsi_state_e g1State, g2State;

  gsi_group uGroupOne (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .startPulse(start1P),
    .ackPulse(ack1P || ackAllP), // [RULE9] [RULE10]
    .stopActive(stop1 || stopAll), // [RULE1] [RULE2]
    .passReturn(passReturn),
    .readback(rdbk1),
    .fdbkLimit(fdbkQ),
    .energise(g1On),
    .state(g1State),
    .faultPulse(g1Fault)
  );

  // separate instance, so a fault here leaves group one alone [RULE7]
  gsi_group uGroupTwo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .startPulse(start2P),
    .ackPulse(ack2P || ackAllP), // [RULE9] [RULE10]
    .stopActive(stop2 || stopAll), // [RULE1] [RULE2]
    .passReturn(passReturn),
    .readback(rdbk2),
    .fdbkLimit(fdbkQ),
    .energise(g2On),
    .state(g2State),
    .faultPulse(g2Fault)
  );

  assign groupOneContactorA = g1On; // [RULE4]
  assign groupOneContactorB = g1On; // [RULE4]
  assign groupTwoContactorA = g2On; // [RULE5]
  assign groupTwoContactorB = g2On; // [RULE5]

  // ****************************************
  // ahb-lite slave
  // ****************************************
  // zero wait states; only words used, hsize is not checked
  // upper address bits alias; only the low byte is decoded
  assign addrPhase = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdataQ;

  function automatic logic [31:0] readMux(input logic [7:0] ofs);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (ofs)
      `GSI_OFS_FDBK: v[`GSI_FDBK_W-1:0] = fdbkQ;
      `GSI_OFS_STATUS: v[11:0] = {failsafeStatus(), stopAll, rdbk2, rdbk1, g2On, g1On,
        2'(g2State), 2'(g1State), stop2, stop1};
      `GSI_OFS_IRQ_STAT: v[`GSI_IRQ_W-1:0] = irqStatQ;
      `GSI_OFS_IRQ_MASK: v[`GSI_IRQ_W-1:0] = irqMaskQ;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic failsafeStatus();
    return filtQ[10];
  endfunction

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wrActQ <= 1'b0;
      wrAddrQ <= 8'h00;
    end else begin
      wrActQ <= addrPhase && hwrite;
      wrAddrQ <= haddr[7:0];
    end
  end

  // read data is fetched at the address edge and stands through the data phase
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hrdataQ <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdataQ <= readMux(haddr[7:0]);
    end
  end

  // the feedback limit steers both readback monitors [RULE14]
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fdbkQ <= FDBK_DEFAULT;
    end else if (wrActQ && wrAddrQ == `GSI_OFS_FDBK) begin
      fdbkQ <= hwdata[`GSI_FDBK_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irqMaskQ <= `GSI_IRQ_MASK_RST;
    end else if (wrActQ && wrAddrQ == `GSI_OFS_IRQ_MASK) begin
      irqMaskQ <= hwdata[`GSI_IRQ_W-1:0];
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  always_comb begin
    irqEvt = '0;
    irqEvt[`GSI_IRQ_G1_FAULT] = g1Fault;
    irqEvt[`GSI_IRQ_G2_FAULT] = g2Fault;
    irqEvt[`GSI_IRQ_G1_STOP] = fallP[0];
    irqEvt[`GSI_IRQ_G2_STOP] = fallP[1];
    irqEvt[`GSI_IRQ_ALL_STOP] = fallP[2];
    irqEvt[`GSI_IRQ_PASS_RET] = passReturn;
    irqClr = (wrActQ && wrAddrQ == `GSI_OFS_IRQ_STAT) ? hwdata[`GSI_IRQ_W-1:0] : '0;
    // an event in the clearing cycle is kept
    irqStatD = (irqStatQ & ~irqClr) | irqEvt;
  end

  // a mask write reaches the pin one cycle after it lands

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irqStatQ <= '0;
      irqQ <= 1'b0;
    end else begin
      irqStatQ <= irqStatD;
      irqQ <= |(irqStatD & irqMaskQ);
    end
  end

  assign irq = irqQ;

  // ****************************************
  // checks
  // ****************************************
  logic ackSeenQ;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ackSeenQ <= 1'b0;
    end else if (ack1P || ack2P || ackAllP) begin
      ackSeenQ <= 1'b1;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  AST_OWN_STOP: assert property (stop1 |=> !groupOneContactorA && !groupOneContactorB) // [RULE1]
    else $error("group stop did not drop group one");
  AST_OWN_ISOLATE: assert property ($fell(g2On) |-> // [RULE1]
    ($past(stop2) || $past(stopAll) || g2State == gsi_pkg::GSI_FAULT || $past(passReturn)))
    else $error("group two dropped without own cause");
  AST_SHARED_STOP: assert property (stopAll |=> !g1On && !g2On) // [RULE2]
    else $error("shared stop left a group on");
  AST_PAIR_ONE: assert property (groupOneContactorA == groupOneContactorB) // [RULE4]
    else $error("group one contactors disagree");
  AST_PAIR_TWO: assert property (groupTwoContactorA == groupTwoContactorB) // [RULE5]
    else $error("group two contactors disagree");
  AST_FAULT_OFF: assert property ((g1State == gsi_pkg::GSI_FAULT) |-> !g1On ##1 !g1On) // [RULE6]
    else $error("faulted group one energised");
  AST_FIRST_ACK: assert property ($rose(g1On) || $rose(g2On) |-> ackSeenQ) // [RULE8]
    else $error("start before any acknowledge");
  AST_START_EDGE: assert property ($rose(g1On) |-> $past(start1P) && $past(rdbk1)) // [RULE15]
    else $error("group one energised without start edge and readback");
  AST_HELD_START: assert property ((groupOneStartRequest && !g1On) [*8] |-> // [RULE18]
    !start1P) else $error("held start retriggered");
  AST_RESET_OFF: assert property (@(posedge clk_sys) $fell(sys_rst) |-> !g1On && !g2On) // [RULE17]
    else $error("contactor on right after reset");
  AST_PASS_DROP: assert property (passReturn |=> !g1On && !g2On) // [RULE11]
    else $error("passivation return left a group on");

  // ****************************************
  // group two checks, group one isolation and held acknowledge, register checks
  // ****************************************
  // group two mirrors group one, so a fault in one cannot hide in the other
  AST_TWO_STOP: assert property (stop2 |=> !groupTwoContactorA && !groupTwoContactorB) // [RULE1]
    else $error("group stop did not drop group two");
  AST_TWO_FAULT_OFF: assert property ((g2State == gsi_pkg::GSI_FAULT) |-> !g2On) // [RULE6]
    else $error("faulted group two energised");
  AST_TWO_START_EDGE: assert property ($rose(g2On) |-> $past(start2P) && $past(rdbk2)) // [RULE15]
    else $error("group two energised without start edge and readback");
  AST_ONE_ISOLATE: assert property ($fell(g1On) |-> // [RULE7]
    ($past(stop1) || $past(stopAll) || g1State == gsi_pkg::GSI_FAULT || $past(passReturn)))
    else $error("group one dropped without own cause");
  AST_HELD_START_TWO: assert property ((groupTwoStartRequest && !g2On) [*8] |-> !start2P) // [RULE18]
    else $error("held start retriggered on group two");
  AST_HELD_ACK: assert property (groupOneAcknowledge [*8] |-> !ack1P) // [RULE18]
    else $error("held acknowledge counted before release");
  AST_RDATA_HOLD: assert property (!(addrPhase && !hwrite) |=> $stable(hrdata))
    else $error("read data moved outside a read");
  AST_FDBK_WRITE: assert property ((wrActQ && wrAddrQ == `GSI_OFS_FDBK) |=> // [RULE14]
    fdbkQ == $past(hwdata[`GSI_FDBK_W-1:0])) else $error("feedback limit write lost");
  AST_MASK_WRITE: assert property ((wrActQ && wrAddrQ == `GSI_OFS_IRQ_MASK) |=>
    irqMaskQ == $past(hwdata[`GSI_IRQ_W-1:0])) else $error("interrupt mask write lost");
  AST_UNMAPPED: assert property ((addrPhase && !hwrite && haddr[7:0] > `GSI_OFS_IRQ_MASK) |=>
    hrdata == 32'h0000_0000) else $error("unmapped read returned data");
  AST_STATUS_STOP: assert property ((addrPhase && !hwrite && haddr[7:0] == `GSI_OFS_STATUS) |=> // [RULE13]
    hrdata[0] == $past(stop1)) else $error("status read lost the group one stop");

  // sticky bits: only a written one clears, and an event in that cycle wins
  generate
    for (gi = 0; gi < `GSI_IRQ_W; gi++) begin : gIrqChk
      AST_IRQ_SET: assert property (irqEvt[gi] |=> irqStatQ[gi])
        else $error("interrupt event not recorded");
      AST_IRQ_STICKY: assert property ((irqStatQ[gi] && !irqClr[gi]) |=> irqStatQ[gi])
        else $error("interrupt status bit lost without a clear");
    end
  endgenerate

  COV_BOTH_RUN: cover property (g1On && g2On);
  COV_FAULT_OTHER_RUN: cover property (g1State == gsi_pkg::GSI_FAULT && g2On);
  COV_SHARED_DROP: cover property (g1On && g2On && stopAll ##1 !g1On && !g2On);
  COV_PASS_RET: cover property (passReturn);
  COV_FAULT_TWO_ONE_RUN: cover property (g2State == gsi_pkg::GSI_FAULT && g1On);
endmodule // gsi_top

// ==== bench/gsi_field_model.sv ====
// contactor pair model with a normally closed readback contact
`timescale 1ns/1ps
module gsi_field_model #(
  parameter int DLY = 4
) (
  // clock
  input wire logic clk_sys,
  // coils and fault injection
  input wire logic coilA,
  input wire logic coilB,
  input wire logic weld,
  // auxiliary contact
  output logic readback
);
  // ****************************************
  // contact travel
  // ****************************************
  logic [DLY-1:0] pullQ = '0;
  always @(posedge clk_sys) begin
    pullQ <= {pullQ[DLY-2:0], coilA | coilB};
  end
  // high only when both dropped out; a welded pair keeps it low
  assign readback = weld ? 1'b0 : ~pullQ[DLY-1];
endmodule // gsi_field_model

// ==== bench/gsi_top_tb.sv ====
// self-checking bench of the group shutdown interlock
`timescale 1ns/1ps
`include "gsi_defs.svh"
module gsi_top_tb;
  // button indices: starts, acknowledges, then stops
  localparam int S1 = 0, S2 = 1, A1 = 2, A2 = 3, AA = 4, E1 = 5, E2 = 6, EA = 7;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic passive = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] btn = 8'h00;
  logic [1:0] weld = 2'h0;
  logic hreadyout, irq, hresp;
  logic [31:0] hrdata, rdat;
  logic [1:0] rb;
  logic [3:0] k;
  int failures = 0;
  int checks = 0;
  always #25 clk_sys = ~clk_sys;
  gsi_top #(.FDBK_DEFAULT(24'h000010)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .groupOneEmergencyStopN(~btn[E1]), .groupTwoEmergencyStopN(~btn[E2]), .sharedEmergencyStopN(~btn[EA]),
    .groupOneStartRequest(btn[S1]), .groupTwoStartRequest(btn[S2]), .groupOneAcknowledge(btn[A1]),
    .groupTwoAcknowledge(btn[A2]), .sharedAcknowledge(btn[AA]), .groupOneReadback(rb[0]),
    .groupTwoReadback(rb[1]), .failsafeInputModulePassive(passive), .groupOneContactorA(k[0]),
    .groupOneContactorB(k[1]), .groupTwoContactorA(k[2]), .groupTwoContactorB(k[3]), .irq(irq)
  );
  gsi_field_model fieldOne (.clk_sys(clk_sys), .coilA(k[0]), .coilB(k[1]), .weld(weld[0]), .readback(rb[0]));
  gsi_field_model fieldTwo (.clk_sys(clk_sys), .coilA(k[2]), .coilB(k[3]), .weld(weld[1]), .readback(rb[1]));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // held well past the four-edge pin filter
  task automatic press(input int b);
    btn[b] <= 1'b1;
    cyc(8);
    btn[b] <= 1'b0;
    cyc(8);
  endtask
  task automatic rdy();
    for (int i = 0; i < 20; i++) begin
      cyc(1);
      if (hreadyout === 1'b1) return;
    end
    check("hreadyout", 32'h0, 32'h1);
    print_verdict();
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    check("hresp", 32'(hresp), 32'h0);
    rdat = hrdata;
  endtask
  // sampled at the falling edge, away from the contactor flop update
  task automatic grp(input int g, input logic on);
    logic [1:0] p;
    p = ~{on, on};
    for (int i = 0; i < 40 && p !== {on, on}; i++) begin
      @(negedge clk_sys);
      p = k[2*g+:2];
    end
    @(posedge clk_sys);
    check($sformatf("group%0dCoils", g + 1), 32'(p), {30'h0, on, on});
    if (p !== {on, on}) print_verdict();
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic scn_registers();
    bus(1'b0, `GSI_OFS_FDBK, 32'h0);
    check("feedbackLimit", rdat, 32'h10);
    bus(1'b1, `GSI_OFS_FDBK, 32'h20);
    bus(1'b0, `GSI_OFS_FDBK, 32'h0);
    check("feedbackLimitWritten", rdat, 32'h20);
    bus(1'b1, `GSI_OFS_FDBK, 32'h10);
    bus(1'b0, `GSI_OFS_IRQ_MASK, 32'h0);
    check("irqMask", rdat, 32'(`GSI_IRQ_MASK_RST));
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    bus(1'b0, 8'h10, 32'h0);
    check("unmapped", rdat, 32'h0);
  endtask
  task automatic scn_first_start();
    press(S1);
    cyc(30);
    grp(0, 1'b0);
    btn[AA] <= 1'b1;
    cyc(16);
    btn[S1] <= 1'b1;
    cyc(16);
    btn[AA] <= 1'b0;
    cyc(30);
    grp(0, 1'b0);
    btn[S1] <= 1'b0;
    cyc(16);
    press(S1);
    grp(0, 1'b1);
    grp(1, 1'b0);
    press(S2);
    grp(1, 1'b1);
    grp(0, 1'b1);
  endtask
  task automatic scn_group_stop();
    press(E1);
    grp(0, 1'b0);
    grp(1, 1'b1);
    check("irqMasked", 32'(irq), 32'h0);
    bus(1'b0, `GSI_OFS_IRQ_STAT, 32'h0);
    check("stopFlag", rdat, 32'h1 << `GSI_IRQ_G1_STOP);
    bus(1'b1, `GSI_OFS_IRQ_STAT, 32'h1 << `GSI_IRQ_G1_STOP);
    bus(1'b0, `GSI_OFS_IRQ_STAT, 32'h0);
    check("stopFlagCleared", rdat, 32'h0);
    press(S1);
    cyc(30);
    grp(0, 1'b0);
    press(A1);
    press(S1);
    grp(0, 1'b1);
  endtask
  task automatic scn_shared_stop();
    bus(1'b1, `GSI_OFS_IRQ_MASK, 32'h1 << `GSI_IRQ_ALL_STOP);
    press(EA);
    grp(0, 1'b0);
    grp(1, 1'b0);
    check("irqRaised", 32'(irq), 32'h1);
    bus(1'b1, `GSI_OFS_IRQ_STAT, 32'h1 << `GSI_IRQ_ALL_STOP);
    cyc(2);
    check("irqCleared", 32'(irq), 32'h0);
    press(AA);
    press(S1);
    press(S2);
    grp(0, 1'b1);
    grp(1, 1'b1);
  endtask
  // a welded pair is found after stopping, while the coils are off
  task automatic scn_weld();
    weld[0] <= 1'b1;
    press(E1);
    grp(0, 1'b0);
    cyc(40);
    bus(1'b0, `GSI_OFS_STATUS, 32'h0);
    check("groupOneState", 32'(rdat[3:2]), 32'(gsi_pkg::GSI_FAULT));
    bus(1'b0, `GSI_OFS_IRQ_STAT, 32'h0);
    check("faultFlag", 32'(rdat[`GSI_IRQ_G1_FAULT]), 32'h1);
    press(E2);
    grp(1, 1'b0);
    press(A2);
    press(S2);
    grp(1, 1'b1);
    press(A1);
    press(S1);
    cyc(30);
    grp(0, 1'b0);
    weld[0] <= 1'b0;
    cyc(16);
    press(AA);
    press(S1);
    grp(0, 1'b1);
    grp(1, 1'b1);
    weld[1] <= 1'b1;
    press(E2);
    grp(1, 1'b0);
    cyc(40);
    bus(1'b0, `GSI_OFS_IRQ_STAT, 32'h0);
    check("groupTwoFaultFlag", 32'(rdat[`GSI_IRQ_G2_FAULT]), 32'h1);
    grp(0, 1'b1);
    weld[1] <= 1'b0;
    cyc(16);
    press(A2);
    press(S2);
    grp(1, 1'b1);
  endtask
  task automatic scn_passive();
    passive <= 1'b1;
    cyc(16);
    passive <= 1'b0;
    grp(0, 1'b0);
    grp(1, 1'b0);
    bus(1'b0, `GSI_OFS_IRQ_STAT, 32'h0);
    check("passReturnFlag", 32'(rdat[`GSI_IRQ_PASS_RET]), 32'h1);
    press(S1);
    cyc(30);
    grp(0, 1'b0);
    press(AA);
    press(S1);
    grp(0, 1'b1);
  endtask
  initial begin
    cyc(8);
    check("resetCoils", 32'(k), 32'h0);
    cyc(8);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    @(negedge clk_sys);
    check("releaseCoils", 32'(k), 32'h0);
    cyc(8);
    scn_registers();
    scn_first_start();
    scn_group_stop();
    scn_shared_stop();
    scn_weld();
    scn_passive();
    print_verdict();
  end
endmodule // gsi_top_tb
